// file: fsr_regs.sv
// status and flash current register bank of the LED flash driver
//
// Overview of operation
// - The fault status register resets to 0x00 and clears on a host read and on supply undervoltage.
// - No new flash or torch event starts while any fault flag is latched; the host clears it first.
// - Fault bits 7 and 6 flag a shorted LED on regulator 1 and regulator 2.
// - Fault bit 5 flags an invalid regulator supply, bit 4 an invalid main supply or die overheat.
// - Fault bit 3 flags thermistor overtemperature, bit 2 a thermistor node shorted to ground.
// - Fault bit 1 flags analog-loop overvoltage, bit 0 digital-loop overvoltage.
// - The event status register resets to 0x01 and clears on read, undervoltage and a new event.
// - Event bit 7 records low-battery current reduction during the latest flash event.
// - Event bit 6 reads 0 while an event runs and 1 once it has completed.
// - Event bits 5 and 4 record transmit mask 1 and 2 during the latest flash event.
// - Event bits 3 and 2 record flash and torch safety timer expiry in maximum timer mode.
// - Event bit 1 is set whenever the inductor peak current limit is reached.
// - Event bit 0 reads 1 after a register reset and clears when the host reads it.
// - The flash current register resets to 0x29, bit 7 enables regulator 1, bit 6 reads 0.
// - The flash enable clears itself on lockout, supply undervoltage or an LED1 flash fault.
// - The 6-bit code maps linearly in 15.625 mA steps from 15.625 mA up to 1000 mA.
`timescale 1ns/1ns
`default_nettype none
module fsr_regs (
  // clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    reset_n,
  // register access from the serial bus front end
  input  wire fsr_pkg::fsr_reg_req_t   reg_req,
  output logic                  [7:0]  reg_rdata_ff,
  // fault and event conditions
  input  wire fsr_pkg::fsr_fault_in_t  fault_in,
  input  wire fsr_pkg::fsr_event_in_t  event_in,
  // supply and protection
  input  wire logic                    supply_undervoltage_threshold_hit,
  input  wire logic                    lockout,
  input  wire logic                    led1_flash_fault,
  // event sequencing
  output logic                         event_start_ff,
  output logic                         event_busy_ff,
  output logic                         fault_pending_ff,
  // regulator 1 flash settings
  output logic                         reg_a_flash_enable_ff,
  output logic                  [5:0]  reg_a_flash_current_code_ff,
  output logic                  [19:0] reg_a_flash_current_ua_ff
);
  import fsr_pkg::*;

  // flash current in microamps for a code
  function automatic logic [19:0] fsr_code_to_ua(input logic [5:0] code);
    logic [31:0] wide;
    wide = (32'(code) + 32'h0000_0001) * 32'(FLASH_STEP_UA);
    return wide[19:0];
  endfunction : fsr_code_to_ua

  logic [7:0]  fault_q;
  logic [7:0]  event_q;
  logic [7:0]  fault_set;
  logic [7:0]  event_set;
  logic        rd_fault;
  logic        rd_event;
  logic        wr_flash;
  logic        grant;
  logic        busy;
  logic        fault_latched;
  logic        en_clear;
  logic [7:0]  nxt_rdata;
  logic        nxt_enable;
  logic [5:0]  nxt_code;
  logic        nxt_pending;

  // address decode of read and write strobes
  always_comb begin
    rd_fault = reg_req.rd && (reg_req.addr == ADDR_FAULT_STATUS);
    rd_event = reg_req.rd && (reg_req.addr == ADDR_EVENT_STATUS);
    wr_flash = reg_req.wr && (reg_req.addr == ADDR_FLASH_CURRENT);
  end

  // fault flags map straight onto the fault status bits
  always_comb begin
    fault_set = fault_in;
  end

  // fault status, cleared by read or undervoltage; set wins
  fsr_flag_bank #(
    .RST      (RST_FAULT_STATUS)
  ) u_fault (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .set_bits (fault_set),
    .clear    (rd_fault || supply_undervoltage_threshold_hit),
    .flags_ff (fault_q)
  );

  // a fault raised this cycle also blocks a start
  always_comb begin
    fault_latched = (fault_q != 8'h00) || (fault_set != 8'h00);
  end

  // event sequencer
  fsr_event_ctl u_ctl (
    .clk_sys       (clk_sys),
    .reset_n       (reset_n),
    .request       (event_in.event_request),
    .finished      (event_in.event_finished),
    .fault_latched (fault_latched),
    .grant         (grant),
    .busy_ff       (busy)
  );

  // event flags: per-event records only while an event runs
  always_comb begin
    event_set           = 8'h00;
    event_set[EV_LOWBAT] = event_in.low_battery_active && busy;
    event_set[EV_DONE]  = event_in.event_finished && busy;
    event_set[EV_TX1]   = event_in.transmit_mask_one && busy;
    event_set[EV_TX2]   = event_in.transmit_mask_two && busy;
    event_set[EV_FTMR]  = event_in.flash_timer_out && event_in.max_timer_mode;
    event_set[EV_TTMR]  = event_in.torch_timer_out && event_in.max_timer_mode;
    event_set[EV_INDUCTOR_PEAK_LIMIT_HIT]  = event_in.inductor_peak_limit;
  end

  // event status, reset value carries the registers-were-reset bit
  fsr_flag_bank #(
    .RST      (RST_EVENT_STATUS)
  ) u_event (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .set_bits (event_set),
    .clear    (rd_event || supply_undervoltage_threshold_hit || grant),
    .flags_ff (event_q)
  );

  // flash enable: self clear wins over a host write for safety
  always_comb begin
    en_clear   = lockout || supply_undervoltage_threshold_hit || led1_flash_fault;
    nxt_enable = reg_a_flash_enable_ff;
    nxt_code   = reg_a_flash_current_code_ff;
    if (wr_flash) begin
      nxt_enable = reg_req.wdata[FC_EN_BIT];
      nxt_code   = reg_req.wdata[FC_CODE_MSB:0];
    end
    if (en_clear) begin
      nxt_enable = 1'b0;
    end
  end

  // read mux returns values before any clearing; bit 6 of current reads 0
  always_comb begin
    case (reg_req.addr)
      ADDR_FAULT_STATUS:  nxt_rdata = fault_q;
      ADDR_EVENT_STATUS:  nxt_rdata = event_q;
      ADDR_FLASH_CURRENT: nxt_rdata = {reg_a_flash_enable_ff, 1'b0, reg_a_flash_current_code_ff};
      default:            nxt_rdata = READ_UNMAPPED;
    endcase
    nxt_pending = fault_latched;
  end

  // output registers
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      reg_rdata_ff                <= 8'h00;
      event_start_ff              <= 1'b0;
      event_busy_ff               <= 1'b0;
      fault_pending_ff            <= 1'b0;
      reg_a_flash_enable_ff       <= RST_FLASH_CURRENT[FC_EN_BIT];
      reg_a_flash_current_code_ff <= RST_FLASH_CURRENT[FC_CODE_MSB:0];
      reg_a_flash_current_ua_ff   <= fsr_code_to_ua(RST_FLASH_CURRENT[FC_CODE_MSB:0]);
    end else begin
      if (reg_req.rd) begin
        reg_rdata_ff <= nxt_rdata;
      end
      event_start_ff              <= grant;
      event_busy_ff               <= busy;
      fault_pending_ff            <= nxt_pending;
      reg_a_flash_enable_ff       <= nxt_enable;
      reg_a_flash_current_code_ff <= nxt_code;
      reg_a_flash_current_ua_ff   <= fsr_code_to_ua(nxt_code);
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_read_fault;
    rd_fault && (fault_set == 8'h00);
  endsequence

  sequence s_read_event;
    rd_event && (event_set == 8'h00) && !grant;
  endsequence

  // steps of an accepted start: pulse first, busy output one cycle later
  sequence s_start_pulse;
    event_start_ff && !event_busy_ff;
  endsequence

  sequence s_busy_shown;
    event_busy_ff && !event_start_ff;
  endsequence

  fault_read_clear_a: assert property (s_read_fault |=> fault_q == 8'h00)
    else $error("fault status not cleared by read");
  fault_uv_clear_a: assert property ((supply_undervoltage_threshold_hit
    && fault_set == 8'h00) |=> fault_q == 8'h00)
    else $error("fault status not cleared by undervoltage");
  no_fault_start_a: assert property ((fault_q != 8'h00) |=> !event_start_ff)
    else $error("event started with latched fault");
  short_flags_a: assert property (fault_in.reg_a_short_flag || fault_in.reg_b_short_flag
    |=> (fault_q[7] || !$past(fault_in.reg_a_short_flag))
    && (fault_q[6] || !$past(fault_in.reg_b_short_flag)))
    else $error("short flag not latched");
  supply_flags_a: assert property (fault_in.regulator_supply_invalid |=> fault_q[5])
    else $error("regulator supply flag not latched");
  therm_flags_a: assert property (fault_in.input_or_thermal_fault |=> fault_q[4])
    else $error("input or thermal flag not latched");
  ntc_flags_a: assert property (fault_in.thermistor_grounded |=> fault_q[2])
    else $error("thermistor ground flag not latched");
  ovp_flags_a: assert property (fault_in.overvoltage_digital_loop |=> fault_q[0])
    else $error("digital overvoltage flag not latched");
  start_clear_a: assert property ((grant && event_set == 8'h00) |=> event_q == 8'h00
    ##1 event_start_ff == 1'b0)
    else $error("event status not cleared at start");
  lowbat_rec_a: assert property ((event_in.low_battery_active && busy) |=> event_q[7])
    else $error("low battery reduction not recorded");
  done_busy_a: assert property (busy |-> !event_q[EV_DONE])
    else $error("done bit high during event");
  txmask_rec_a: assert property ((event_in.transmit_mask_two && busy) |=> event_q[4])
    else $error("transmit mask two not recorded");
  timer_mode_a: assert property ((event_in.flash_timer_out && !event_in.max_timer_mode
    && !event_q[3]) |=> !event_q[3] || $past(event_in.max_timer_mode))
    else $error("flash timer flag outside maximum timer mode");
  inductor_peak_limit_hit_rec_a: assert property (event_in.inductor_peak_limit |=> event_q[1])
    else $error("peak limit not recorded");
  reset_flag_a: assert property (s_read_event |=> !event_q[EV_RESET])
    else $error("reset indication not cleared by read");
  enable_write_a: assert property ((wr_flash && reg_req.wdata[7] && !en_clear)
    |=> reg_a_flash_enable_ff)
    else $error("flash enable write lost");
  enable_clear_a: assert property (en_clear |=> !reg_a_flash_enable_ff)
    else $error("flash enable not cleared on fault");
  current_map_a: assert property (reg_a_flash_current_ua_ff
    == fsr_code_to_ua(reg_a_flash_current_code_ff))
    else $error("flash current mapping wrong");
  set_wins_a: assert property ((rd_fault && fault_set != 8'h00) |=>
    ((fault_q & $past(fault_set)) == $past(fault_set)) && reg_rdata_ff == $past(fault_q))
    else $error("event lost on clearing read");

  // remaining flags, start handshake, read data and current register fields
  therm_hot_a: assert property (fault_in.thermistor_overtemp |=> fault_q[3])
    else $error("thermistor overtemperature flag not latched");
  ovp_analog_a: assert property (fault_in.overvoltage_analog_loop |=> fault_q[1])
    else $error("analog overvoltage flag not latched");
  txmask_one_a: assert property ((event_in.transmit_mask_one && busy)
    |=> event_q[EV_TX1])
    else $error("transmit mask one not recorded");
  flash_timer_a: assert property ((event_in.flash_timer_out && event_in.max_timer_mode)
    |=> event_q[EV_FTMR])
    else $error("flash timer expiry not recorded");
  torch_timer_a: assert property ((event_in.torch_timer_out && event_in.max_timer_mode)
    |=> event_q[EV_TTMR])
    else $error("torch timer expiry not recorded");
  event_uv_clear_a: assert property (supply_undervoltage_threshold_hit
    && event_set == 8'h00 |=> event_q == 8'h00)
    else $error("event status not cleared by undervoltage");
  event_read_clear_a: assert property (s_read_event |=> event_q == 8'h00)
    else $error("event status not cleared by read");
  done_set_a: assert property ((busy && event_in.event_finished)
    |=> event_q[EV_DONE] && !busy)
    else $error("done bit not set at event end");
  reset_bit_hold_a: assert property (!event_q[EV_RESET] |=> !event_q[EV_RESET])
    else $error("reset indication set without a register reset");
  pending_out_a: assert property (fault_q != 8'h00 |=> fault_pending_ff)
    else $error("pending output low with fault latched");
  start_seq_a: assert property (grant |=> s_start_pulse ##1 s_busy_shown)
    else $error("start pulse or busy output out of step");
  busy_refuse_a: assert property (busy |-> !grant)
    else $error("start granted during an event");
  fault_refuse_a: assert property (fault_set != 8'h00 |-> !grant)
    else $error("start granted with a fault raised");
  grant_need_req_a: assert property (grant |-> event_in.event_request)
    else $error("start granted without a request");
  flash_read_a: assert property ((reg_req.rd && reg_req.addr == ADDR_FLASH_CURRENT)
    |=> reg_rdata_ff == {$past(reg_a_flash_enable_ff), 1'b0, $past(reg_a_flash_current_code_ff)})
    else $error("flash current read data wrong");
  unmapped_read_a: assert property ((reg_req.rd && reg_req.addr > ADDR_FLASH_CURRENT)
    |=> reg_rdata_ff == READ_UNMAPPED)
    else $error("unmapped read data not zero");
  event_read_a: assert property (rd_event |=> reg_rdata_ff == $past(event_q))
    else $error("event status read data wrong");
  rdata_hold_a: assert property (!reg_req.rd |=> $stable(reg_rdata_ff))
    else $error("read data changed without a read");
  code_write_a: assert property (wr_flash |=> reg_a_flash_current_code_ff
    == $past(reg_req.wdata[FC_CODE_MSB:0]))
    else $error("flash current code write lost");
  code_hold_a: assert property (!wr_flash |=> $stable(reg_a_flash_current_code_ff))
    else $error("flash current code changed without a write");
  enable_off_write_a: assert property ((wr_flash && !reg_req.wdata[FC_EN_BIT])
    |=> !reg_a_flash_enable_ff)
    else $error("flash enable stuck after a write of zero");
  enable_no_set_a: assert property ((!wr_flash && !reg_a_flash_enable_ff)
    |=> !reg_a_flash_enable_ff)
    else $error("flash enable rose without a write");

endmodule : fsr_regs
`default_nettype wire

// file: fsr_pkg.sv
// package of register map, field positions, reset values and carrier types
package fsr_pkg;

  // register offsets on the serial control bus
  localparam logic [7:0] ADDR_FAULT_STATUS  = 8'h02;
  localparam logic [7:0] ADDR_EVENT_STATUS  = 8'h03;
  localparam logic [7:0] ADDR_FLASH_CURRENT = 8'h04;
  localparam logic [7:0] READ_UNMAPPED      = 8'h00;

  // reset values
  localparam logic [7:0] RST_FAULT_STATUS   = 8'h00;
  localparam logic [7:0] RST_EVENT_STATUS   = 8'h01;
  localparam logic [7:0] RST_FLASH_CURRENT  = 8'h29;

  // flash current register fields
  localparam int FC_EN_BIT   = 7;
  localparam int FC_CODE_MSB = 5;

  // event status bit positions
  localparam int EV_LOWBAT = 7;
  localparam int EV_DONE   = 6;
  localparam int EV_TX1    = 5;
  localparam int EV_TX2    = 4;
  localparam int EV_FTMR   = 3;
  localparam int EV_TTMR   = 2;
  localparam int EV_INDUCTOR_PEAK_LIMIT_HIT   = 1;
  localparam int EV_RESET  = 0;

  // one current step, 15.625 mA, in microamps
  localparam logic [19:0] FLASH_STEP_UA = 20'h03D09;

  // fault conditions, ordered as bits 7 down to 0 of the fault status
  typedef struct packed {
    logic reg_a_short_flag;
    logic reg_b_short_flag;
    logic regulator_supply_invalid;
    logic input_or_thermal_fault;
    logic thermistor_overtemp;
    logic thermistor_grounded;
    logic overvoltage_analog_loop;
    logic overvoltage_digital_loop;
  } fsr_fault_in_t;

  // event conditions and sequencing handshake
  typedef struct packed {
    logic low_battery_active;
    logic transmit_mask_one;
    logic transmit_mask_two;
    logic flash_timer_out;
    logic torch_timer_out;
    logic inductor_peak_limit;
    logic max_timer_mode;
    logic event_request;
    logic event_finished;
  } fsr_event_in_t;

  // byte-level register request from the serial bus front end
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } fsr_reg_req_t;

endpackage : fsr_pkg

// file: fsr_flag_bank.sv
// eight sticky status flags with a clear that loses to a simultaneous set
`timescale 1ns/1ns
`default_nettype none
module fsr_flag_bank #(
  parameter logic [7:0] RST = 8'h00
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  // flag control
  input  wire logic [7:0] set_bits,
  input  wire logic       clear,
  output logic      [7:0] flags_ff
);
  logic [7:0] nxt_flags;

  // clear first, then or in new sets so no event is lost
  always_comb begin
    nxt_flags = (clear ? 8'h00 : flags_ff) | set_bits;
  end

  // flag storage
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      flags_ff <= RST;
    end else begin
      flags_ff <= nxt_flags;
    end
  end
endmodule : fsr_flag_bank
`default_nettype wire

// file: fsr_event_ctl.sv
// flash/torch event sequencer that refuses to start while a fault is latched
`timescale 1ns/1ns
`default_nettype none
module fsr_event_ctl (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic reset_n,
  // event handshake
  input  wire logic request,
  input  wire logic finished,
  input  wire logic fault_latched,
  output logic      grant,
  output logic      busy_ff
);
  typedef enum logic [0:0] {EV_IDLE, EV_ACTIVE} fsr_ev_state_t;
  fsr_ev_state_t state_ff;
  fsr_ev_state_t nxt_state;

  // next state and start grant; requests during an event are ignored
  always_comb begin
    nxt_state = state_ff;
    grant     = 1'b0;
    case (state_ff)
      EV_IDLE: begin
        if (request && !fault_latched) begin
          grant     = 1'b1;
          nxt_state = EV_ACTIVE;
        end
      end
      EV_ACTIVE: begin
        if (finished) begin
          nxt_state = EV_IDLE;
        end
      end
      default: nxt_state = EV_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_ff <= EV_IDLE;
      busy_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      busy_ff  <= (nxt_state == EV_ACTIVE);
    end
  end
endmodule : fsr_event_ctl
`default_nettype wire

// file: fsr_host_model.sv
// host side model that issues single byte register reads and writes
`timescale 1ns/1ns
`default_nettype none
module fsr_host_model (
  // clock
  input  wire logic                  clk_sys,
  // register access
  output var  fsr_pkg::fsr_reg_req_t reg_req,
  input  wire logic            [7:0] reg_rdata_ff
);
  import fsr_pkg::*;

  // idle bus starts with a pattern that is no register
  initial reg_req = '{addr: 8'hA5, wdata: 8'h5A, wr: 1'b0, rd: 1'b0};

  // one strobe cycle, then the released bus shows inverted address and data
  task automatic access(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(posedge clk_sys);
    #1;
    reg_req = '{addr: a, wdata: d, wr: w, rd: ~w};
    @(posedge clk_sys);
    #1;
    reg_req = '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask : access

  // read data is taken just after the edge that samples the strobe
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    access(a, 8'h00, 1'b0);
    d = reg_rdata_ff;
  endtask : read_reg

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    access(a, d, 1'b1);
  endtask : write_reg
endmodule : fsr_host_model
`default_nettype wire

// file: testbench.sv
// self-checking bench for the status and flash current registers
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import fsr_pkg::*;
  // design signals
  logic          clk_sys  = 1'b0;
  logic          reset_n  = 1'b0;
  fsr_reg_req_t  reg_req;
  logic [7:0]    reg_rdata_ff;
  fsr_fault_in_t fault_in = '0;
  fsr_event_in_t event_in = '0;
  logic [2:0]    kill     = 3'h0;  // undervoltage, lockout, led1 fault
  logic          start;
  logic          busy;
  logic          pending;
  logic          fen;
  logic [5:0]    code;
  logic [19:0]   ua;
  // model state and counters
  int            m_fault;
  int            m_event;
  int            m_fc;
  logic [7:0]    rd_val;
  int            err_count   = 0;
  int            checks_done = 0;

  always #2 clk_sys = ~clk_sys;

  fsr_regs fsr_regs_inst (
    .clk_sys(clk_sys), .reset_n(reset_n), .reg_req(reg_req), .reg_rdata_ff(reg_rdata_ff),
    .fault_in(fault_in), .event_in(event_in), .supply_undervoltage_threshold_hit(kill[2]),
    .lockout(kill[1]), .led1_flash_fault(kill[0]), .event_start_ff(start),
    .event_busy_ff(busy), .fault_pending_ff(pending), .reg_a_flash_enable_ff(fen),
    .reg_a_flash_current_code_ff(code), .reg_a_flash_current_ua_ff(ua)
  );
  fsr_host_model fsr_host_model_inst (
    .clk_sys(clk_sys), .reg_req(reg_req), .reg_rdata_ff(reg_rdata_ff)
  );

  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic print_verdict;
    if (err_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  task automatic check_val(input string what, input logic [19:0] exp, input logic [19:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check_val

  // read through the host and compare with the model, which then clears its copy of a read status register
  task automatic rd_chk(input logic [7:0] a);
    logic [7:0] exp;
    exp = (a == ADDR_FAULT_STATUS) ? m_fault[7:0] : (a == ADDR_EVENT_STATUS) ? m_event[7:0] :
          (a == ADDR_FLASH_CURRENT) ? m_fc[7:0] : 8'h00;
    fsr_host_model_inst.read_reg(a, rd_val);
    check_val("read data", {12'h000, exp}, {12'h000, rd_val});
    if (a == ADDR_FAULT_STATUS) m_fault = 0;
    if (a == ADDR_EVENT_STATUS) m_event = 0;
  endtask : rd_chk

  task automatic check_out;
    check_val("flash enable", 20'(m_fc[7]), 20'(fen));
    check_val("current code", 20'(m_fc[5:0]), 20'(code));
    check_val("current ua", 20'((m_fc[5:0] + 1) * 15625), ua);
  endtask : check_out

  task automatic wr_chk(input logic [7:0] a, input logic [7:0] d);
    fsr_host_model_inst.write_reg(a, d);
    if (a == ADDR_FLASH_CURRENT) m_fc = int'(d & 8'hBF);
    check_out();
  endtask : wr_chk

  // request an event; when granted, apply conditions plus a stray request, then finish
  task automatic run_event(input logic [6:0] c, input logic ok);
    event_in.event_request = 1'b1;
    tick();
    event_in.event_request = 1'b0;
    check_val("start pulse", 20'(ok), 20'(start));
    if (ok) begin
      m_event = 0;
      event_in[8:1] = {c, 1'b1};
      tick();
      event_in = '0;
      m_event = {c[6], 1'b0, c[5], c[4], c[3] & c[0], c[2] & c[0], c[1], 1'b0};
      check_val("busy level", 20'h00001, 20'(busy));
      if (c == 7'h00) rd_chk(ADDR_EVENT_STATUS);
      event_in.event_finished = 1'b1;
      tick();
      event_in.event_finished = 1'b0;
      check_val("start while busy", 20'h00000, 20'(start));
      m_event = m_event | 32'h40;
      for (int n = 0; n < 8 && busy !== 1'b0; n++) tick();
      if (busy !== 1'b0) begin
        err_count++;
        print_verdict();
      end
    end
  endtask : run_event

  // hang guard
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    print_verdict();
  end

  // main sequence
  initial begin
    void'($urandom(32'hC5DAAB14));
    m_fault = 0;
    m_event = 1;
    m_fc = 8'h29;
    repeat (16) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    check_out();
    rd_chk(ADDR_FAULT_STATUS);
    rd_chk(ADDR_EVENT_STATUS);
    rd_chk(ADDR_EVENT_STATUS);
    rd_chk(ADDR_FLASH_CURRENT);
    for (int i = 0; i < 8; i++) begin
      fault_in = fsr_fault_in_t'(8'h01 << i);
      tick();
      fault_in = '0;
      m_fault = 1 << i;
      check_val("fault pending", 20'h00001, 20'(pending));
      rd_chk(ADDR_FAULT_STATUS);
      rd_chk(ADDR_FAULT_STATUS);
    end
    // fault raised in the very cycle of its clearing read
    fork
      fsr_host_model_inst.read_reg(ADDR_FAULT_STATUS, rd_val);
      begin
        tick();
        fault_in.overvoltage_digital_loop = 1'b1;
        tick();
        fault_in = '0;
      end
    join
    check_val("read at set", 20'h00000, 20'(rd_val));
    m_fault = 1;
    run_event(7'h00, 1'b0);
    rd_chk(ADDR_FAULT_STATUS);
    event_in.inductor_peak_limit = 1'b1;
    tick();
    event_in.inductor_peak_limit = 1'b0;
    m_event = 2;
    run_event(7'h00, 1'b1);
    rd_chk(ADDR_EVENT_STATUS);
    run_event(7'h7F, 1'b1);
    rd_chk(ADDR_EVENT_STATUS);
    run_event(7'h7E, 1'b1);
    rd_chk(ADDR_EVENT_STATUS);
    // boundary codes, then random bytes
    for (int j = 0; j < 8; j++) begin
      wr_chk(ADDR_FLASH_CURRENT, (j == 0) ? 8'hBF : (j == 1) ? 8'h40 : 8'($urandom));
      rd_chk(ADDR_FLASH_CURRENT);
    end
    wr_chk(ADDR_FAULT_STATUS, 8'hFF);
    rd_chk(ADDR_FAULT_STATUS);
    wr_chk(8'h10, 8'hFF);
    rd_chk(8'h10);
    // every clearing source drops the enable; undervoltage also wipes status
    fault_in.thermistor_grounded = 1'b1;
    event_in.inductor_peak_limit = 1'b1;
    tick();
    fault_in = '0;
    event_in = '0;
    m_fault = 4;
    m_event = 2;
    for (int k = 0; k < 3; k++) begin
      wr_chk(ADDR_FLASH_CURRENT, 8'h80 | 8'($urandom));
      kill = 3'h1 << k;
      tick();
      kill = 3'h0;
      m_fc[7] = 1'b0;
      if (k == 2) begin
        m_fault = 0;
        m_event = 0;
      end
      check_out();
    end
    rd_chk(ADDR_FAULT_STATUS);
    rd_chk(ADDR_EVENT_STATUS);
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
